// ===== shared/ucg_defines.svh
// Offsets, field positions, reset values and sizes for the serial port configuration block
`ifndef UCG_DEFINES_SVH
`define UCG_DEFINES_SVH
`define UCG_ADDR_W            8
`define UCG_DATA_W            8
`define UCG_OFS_ACTIVATE      8'h30
`define UCG_OFS_CONFIG        8'hF0
`define UCG_RST_ACTIVATE      8'h00
`define UCG_RST_CONFIG        8'h00
`define UCG_BIT_ACTIVATE      0
`define UCG_BIT_CLOCK_SOURCE_SELECT       0
`define UCG_BIT_POWER         1
`define UCG_BIT_POLARITY      2
`define UCG_HOST_CFG_MASK     8'h01
`define UCG_EC_CFG_MASK       8'h07
`define UCG_RT_REGS           8
`endif

// ===== shared/ucg_pkg.sv
// Types shared by the serial port configuration block
package ucg_pkg;
  // Power states of the clock gating table
  typedef enum logic [1:0] {
    UCG_DISABLED  = 2'b00,
    UCG_NORMAL    = 2'b01,
    UCG_PREP      = 2'b10,
    UCG_SLEEPING  = 2'b11
  } ucg_state_e;
endpackage

// ===== shared/ucg_rt_if.sv
// Interface between the top and the runtime register bank
`timescale 1ns/1ps
`default_nettype none
interface ucg_rt_if;
  logic       we;     // Write strobe
  logic [2:0] addr;   // Runtime register index
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Registered read data
  logic       rst_n;  // Selected domain reset, active low
  modport top (output we, output addr, output wdata, output rst_n, input rdata);
  modport bank (input we, input addr, input wdata, input rst_n, output rdata);
endinterface
`default_nettype wire

// ===== verilog/ucg_sync2.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module ucg_sync2 #(
  parameter logic RST_VAL = 1'b0  // Level shown while in reset, the idle level of the input
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // Level in and out
  input  wire logic i_d,
  output var  logic o_q
);
  logic meta_r;  // First stage, read only by second stage

  // Two stage capture
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ucg_rt_bank.sv
// Eight-byte runtime register bank with registered read
`timescale 1ns/1ps
`default_nettype none
module ucg_rt_bank #(
  parameter int DEPTH = 8
) (
  // Clock
  input  wire logic i_clock,
  // Register access
  ucg_rt_if.bank    rt
);
  logic [7:0] mem_r [DEPTH];  // Storage

  // Elaboration check: the index is three bits wide
  if (DEPTH != 8) begin : g_bad_depth
    $error("ucg_rt_bank: DEPTH must be 8");
  end

  // Write and registered read, cleared by the selected domain reset
  always_ff @(posedge i_clock or negedge rt.rst_n) begin
    if (!rt.rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= 8'h00;
      rt.rdata <= 8'h00;
    end else begin
      if (rt.we) mem_r[rt.addr] <= rt.wdata;
      rt.rdata <= mem_r[rt.addr];
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ucg_top.sv
// Serial port activation, configuration, power plane and clock request control
// Timing: configuration and read data are registered, one cycle after
// the request. Pin and sleep inputs pass two flip-flops first, so the
// power state follows the sleep input two cycles late. Activity inputs
// are taken to be on the core clock and feed the idle flag directly.
// The runtime bank keeps its contents across sleep; only the resets
// chosen by the power bit clear it.
`timescale 1ns/1ps
`default_nettype none
`include "ucg_defines.svh"
module ucg_top
  import ucg_pkg::*;
(
  // Clock and system reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // Host side reset from outside, active low
  input  wire logic       i_host_side_reset_n,
  // Host configuration port
  input  wire logic       i_host_we,
  input  wire logic [7:0] i_host_addr,
  input  wire logic [7:0] i_host_wdata,
  output logic      [7:0] o_host_rdata,
  // Controller configuration port
  input  wire logic       i_ec_we,
  input  wire logic [7:0] i_ec_addr,
  input  wire logic [7:0] i_ec_wdata,
  output logic      [7:0] o_ec_rdata,
  // Runtime register access, index 0 to 7
  input  wire logic       i_rt_we,
  input  wire logic [2:0] i_rt_addr,
  input  wire logic [7:0] i_rt_wdata,
  output logic      [7:0] o_rt_rdata,
  // Clock sources
  input  wire logic       i_ring_osc_clk,
  input  wire logic       i_ext_clk,
  output logic            o_uart_clk,
  // Activity from the serial data path
  input  wire logic       i_tx_active,
  input  wire logic       i_rx_active,
  input  wire logic       i_timeout_active,
  // Sleep handshake
  input  wire logic       i_sleep,
  output logic            o_clock_required,
  output logic            o_idle,
  output logic      [1:0] o_power_state,
  // Block enable towards the data path
  output logic            o_port_enable,
  // Serial line, core side and pins
  input  wire logic       i_core_tx,
  output logic            o_core_rx,
  output logic            o_tx_pin,
  output logic            o_tx_pin_oe_n,
  input  wire logic       i_rx_pin
);
  // Configuration state
  logic       activate_r;     // Activate bit
  logic [2:0] config_r;       // Polarity, power, clock source
  // Synchronised inputs
  logic       host_rst_s;     // Host reset, synchronised, active low
  logic       sleep_s;        // Sleep request, synchronised
  logic       rx_pin_s;       // Receive pin, synchronised
  // Decoded controls
  wire        clock_source_select    = config_r[`UCG_BIT_CLOCK_SOURCE_SELECT];
  wire        power_main = config_r[`UCG_BIT_POWER];
  wire        polarity   = config_r[`UCG_BIT_POLARITY];
  ucg_state_e state;          // Current table state

  // Elaboration check: read path pads the implemented bits to one byte
  if (`UCG_DATA_W != 8) begin : g_bad_data_w
    $error("ucg_top: configuration data must be one byte");
  end

  // Offset match, shared by both configuration ports
  function automatic logic ofs_hit(
    input logic [7:0] addr,    // Offset presented
    input logic [7:0] ofs      // Offset of the register
  );
    ofs_hit = (addr == ofs);
  endfunction

  // Read value of an offset; reserved bits and unmapped offsets read zero
  function automatic logic [7:0] cfg_read(
    input logic [7:0] addr,    // Offset presented
    input logic       act,     // Activate bit
    input logic [2:0] cfg      // Configuration bits
  );
    logic [7:0] val;           // Assembled byte
    val = 8'h00;
    if (addr == `UCG_OFS_ACTIVATE) begin
      // Activate sits alone in bit zero
      val = {7'h00, act};
    end else if (addr == `UCG_OFS_CONFIG) begin
      // Polarity, power and clock source in the low bits
      val = {5'h00, cfg};
    end
    cfg_read = val;
  endfunction

  // Line sense, shared by the transmit and receive directions
  function automatic logic line_sense(
    input logic level,         // Level before inversion
    input logic invert         // Polarity bit
  );
    line_sense = level ^ invert;
  endfunction

  ucg_rt_if rt ();

  // Host reset synchroniser
  ucg_sync2 u_sync_rst (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_d     (i_host_side_reset_n),
    .o_q     (host_rst_s)
  );

  // Sleep input synchroniser
  ucg_sync2 u_sync_sleep (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_d     (i_sleep),
    .o_q     (sleep_s)
  );

  // Receive pin synchroniser; resets to the idle line level so that
  // the data path sees no false start bit after reset
  ucg_sync2 #(
    .RST_VAL (1'b1)
  ) u_sync_rx (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_d     (i_rx_pin),
    .o_q     (rx_pin_s)
  );

  // Address decode for both configuration ports
  wire host_act_hit = ofs_hit(i_host_addr, `UCG_OFS_ACTIVATE);  // Host at activate
  wire host_cfg_hit = ofs_hit(i_host_addr, `UCG_OFS_CONFIG);    // Host at configuration
  wire ec_act_hit   = ofs_hit(i_ec_addr, `UCG_OFS_ACTIVATE);    // Controller at activate
  wire ec_cfg_hit   = ofs_hit(i_ec_addr, `UCG_OFS_CONFIG);      // Controller at configuration

  // Writable bit masks, trimmed to the three implemented bits
  wire [2:0] host_mask = 3'(`UCG_HOST_CFG_MASK);  // Host: clock source only
  wire [2:0] ec_mask   = 3'(`UCG_EC_CFG_MASK);    // Controller: all three bits

  // Host may only write clock source; controller writes all three bits.
  // Bits the host may not touch keep their value, so a host write never
  // moves the power plane or the line polarity behind the controller.
  wire [2:0] host_cfg_nxt = (config_r & ~host_mask) |
                            (i_host_wdata[2:0] & host_mask);
  wire [2:0] ec_cfg_nxt   = i_ec_wdata[2:0] & ec_mask;

  // Configuration registers, system reset; controller wins a collision.
  // Both registers live on the standby plane, so only the system reset
  // clears them; the host side reset never does.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      activate_r <= 1'(`UCG_RST_ACTIVATE);
      config_r   <= 3'(`UCG_RST_CONFIG);
    end else begin
      if (i_ec_we && ec_act_hit) begin
        activate_r <= i_ec_wdata[`UCG_BIT_ACTIVATE];
      end else if (i_host_we && host_act_hit) begin
        activate_r <= i_host_wdata[`UCG_BIT_ACTIVATE];
      end
      if (i_ec_we && ec_cfg_hit) begin
        config_r <= ec_cfg_nxt;
      end else if (i_host_we && host_cfg_hit) begin
        config_r <= host_cfg_nxt;
      end
    end
  end

  // Read data, registered; unmapped offsets read zero, reserved bits zero
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_rdata <= 8'h00;
      o_ec_rdata   <= 8'h00;
    end else begin
      // Each port reads at its own offset every cycle
      o_host_rdata <= cfg_read(i_host_addr, activate_r, config_r);
      o_ec_rdata   <= cfg_read(i_ec_addr, activate_r, config_r);
    end
  end

  // Port enable follows activate
  assign o_port_enable = activate_r;

  // Host reset is honoured only on the main plane
  wire host_rst_act = power_main && !host_rst_s;

  // Runtime bank reset: system reset always, host reset on main plane.
  // The host term comes from a flip-flop and the power bit from a
  // register, so the derived reset changes only just after a clock edge.
  // Writes are dropped while the port is inactive.
  assign rt.rst_n = i_nrst && !host_rst_act;
  assign rt.we    = i_rt_we && activate_r;
  assign rt.addr  = i_rt_addr;
  assign rt.wdata = i_rt_wdata;
  assign o_rt_rdata = rt.rdata;

  // Runtime register bank, contents held across sleep
  ucg_rt_bank #(
    .DEPTH (`UCG_RT_REGS)
  ) u_bank (
    .i_clock (i_clock),
    .rt      (rt)
  );

  // Working clock select, gated off while inactive.
  // The two sources are unrelated, so switching the select while the
  // port runs can give a short pulse; change the source only while
  // activate is clear, when the gate holds the output low.
  wire clk_mux = clock_source_select ? i_ext_clk : i_ring_osc_clk;
  assign o_uart_clk = clk_mux & activate_r;

  // Line polarity and pin drive
  logic tx_pin_r;   // Registered transmit level
  logic tx_oe_n_r;  // Registered transmit enable, low drives
  wire  tx_level  = line_sense(i_core_tx, polarity);
  wire  pin_float = host_rst_act || !activate_r;

  // Pin drive register; enable is low while driving, high while the
  // pin floats for a host reset on the main plane or while inactive
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_pin_r  <= 1'b1;
      tx_oe_n_r <= 1'b1;
      o_core_rx <= 1'b1;
    end else begin
      tx_pin_r  <= tx_level;
      tx_oe_n_r <= pin_float;
      o_core_rx <= line_sense(rx_pin_s, polarity);
    end
  end
  assign o_tx_pin      = tx_pin_r;
  assign o_tx_pin_oe_n = tx_oe_n_r;

  // Idle detection from all three activity sources.
  // Activity comes from the data path on this clock, so it is used as
  // it stands; any one source busy makes the block not idle.
  assign o_idle = !(i_tx_active || i_rx_active || i_timeout_active);

  // Power state from the gating table.
  // Priority: inactive first, then the synchronised sleep request,
  // then the idle flag; every path assigns the state.
  always_comb begin
    if (!activate_r) begin
      state = UCG_DISABLED;
    end else if (!sleep_s) begin
      state = UCG_NORMAL;
    end else if (!o_idle) begin
      state = UCG_PREP;
    end else begin
      state = UCG_SLEEPING;
    end
  end
  assign o_power_state = state;

  // Clock request output per state.
  // Preparing to sleep keeps the core clock so pending work completes.
  always_comb begin
    case (state)
      UCG_DISABLED: o_clock_required = 1'b0;
      UCG_NORMAL:   o_clock_required = !o_idle;
      UCG_PREP:     o_clock_required = 1'b1;
      UCG_SLEEPING: o_clock_required = 1'b0;
      default:      o_clock_required = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== bench/ucg_far_model.sv
// Far side model: clock sources and a serial line with pull-up
`timescale 1ns/1ps
`default_nettype none
module ucg_far_model (
  // Line from the device
  input  wire logic i_tx_pin,
  input  wire logic i_tx_pin_oe_n,
  // Clocks and line towards the device
  output var  logic o_ring_osc_clk,
  output var  logic o_ext_clk,
  output wire logic o_rx_pin
);
  // Free running sources, unrelated periods
  initial o_ring_osc_clk = 1'b0;
  initial o_ext_clk = 1'b0;
  always #7.75 o_ring_osc_clk = ~o_ring_osc_clk;
  always #21 o_ext_clk = ~o_ext_clk;
  // Loop back; pull-up holds the line when released
  assign o_rx_pin = i_tx_pin_oe_n ? 1'b1 : i_tx_pin;
endmodule
`default_nettype wire

// ===== bench/ucg_chk_asserts.sv
// Assertions on the configuration block ports
`timescale 1ns/1ps
`default_nettype none
module ucg_chk
  import ucg_pkg::*;
(
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_nrst,
  // Activity and sleep
  input wire logic       i_tx_active,
  input wire logic       i_rx_active,
  input wire logic       i_timeout_active,
  input wire logic       i_sleep,
  // Status outputs
  input wire logic       o_clock_required,
  input wire logic       o_idle,
  input wire logic       o_port_enable,
  input wire logic       o_uart_clk,
  input wire logic       o_tx_pin_oe_n,
  input wire logic [1:0] o_power_state
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Sleep is seen two edges late through the synchroniser
  property p_idle; o_idle == !(i_tx_active || i_rx_active || i_timeout_active); endproperty
  property p_dis; !o_port_enable |-> !o_clock_required; endproperty
  property p_dis_st; !o_port_enable |-> o_power_state == UCG_DISABLED; endproperty
  property p_float; !o_port_enable && $past(!o_port_enable) |-> o_tx_pin_oe_n; endproperty
  property p_uclk; !o_port_enable |-> !o_uart_clk; endproperty
  property p_norm; o_port_enable && !$past(i_sleep, 2)
    |-> o_clock_required == !o_idle && o_power_state == UCG_NORMAL; endproperty
  property p_prep; o_port_enable && $past(i_sleep, 2) && !o_idle
    |-> o_clock_required && o_power_state == UCG_PREP; endproperty
  property p_sleep; o_port_enable && $past(i_sleep, 2) && o_idle
    |-> !o_clock_required && o_power_state == UCG_SLEEPING; endproperty
  a_idle: assert property (p_idle) else $error("idle mismatch");
  a_dis: assert property (p_dis) else $error("clock request while off");
  a_dis_st: assert property (p_dis_st) else $error("state not disabled");
  a_float: assert property (p_float) else $error("pin driven while off");
  a_uclk: assert property (p_uclk) else $error("port clock while off");
  a_norm: assert property (p_norm) else $error("normal state wrong");
  a_prep: assert property (p_prep) else $error("preparing state wrong");
  a_sleep: assert property (p_sleep) else $error("sleeping state wrong");
  // Main power states reached
  c_prep: cover property (o_power_state == UCG_PREP);
  c_sleep: cover property (o_power_state == UCG_SLEEPING);
  c_norm: cover property (o_power_state == UCG_NORMAL && o_clock_required);
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking testbench for the serial port configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ucg_defines.svh"
module testbench
  import ucg_pkg::*;
;
  logic i_clock = 0, i_nrst = 0, i_host_side_reset_n = 1, i_sleep = 0, i_core_tx = 1;
  logic i_host_we = 0, i_ec_we = 0, i_rt_we = 0;
  logic [7:0] i_host_addr = 0, i_host_wdata = 0, i_ec_addr = 0, i_ec_wdata = 0;
  logic [7:0] i_rt_wdata = 0, o_host_rdata, o_ec_rdata, o_rt_rdata;
  logic [2:0] i_rt_addr = 3'h3, act = 0;
  logic o_uart_clk, o_clock_required, o_idle, o_port_enable, o_core_rx, o_tx_pin, o_tx_pin_oe_n;
  logic [1:0] o_power_state;
  wire i_ring_osc_clk, i_ext_clk, i_rx_pin;
  wire i_tx_active = act[0], i_rx_active = act[1], i_timeout_active = act[2];
  int fails = 0, n_checks = 0, cyc = 0;
  always #4 i_clock = ~i_clock;
  ucg_top DUT (.*);
  ucg_far_model u_far (.i_tx_pin(o_tx_pin), .i_tx_pin_oe_n(o_tx_pin_oe_n),
    .o_ring_osc_clk(i_ring_osc_clk), .o_ext_clk(i_ext_clk), .o_rx_pin(i_rx_pin));
  task automatic chk(input logic [7:0] seen, exp, input string w);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input bit ec, input logic [7:0] a, d);
    {i_ec_we, i_host_we} = ec ? 2'h2 : 2'h1;
    {i_ec_addr, i_ec_wdata, i_host_addr, i_host_wdata} = {a, d, a, d};
    tick();
    {i_ec_we, i_host_we} = 2'h0;
    tick();
  endtask
  task automatic rd(input bit ec, input logic [7:0] a, exp);
    {i_ec_addr, i_host_addr} = {a, a};
    tick();
    chk(ec ? o_ec_rdata : o_host_rdata, exp, "rdata");
  endtask
  task automatic rt(input bit we, input logic [7:0] d, exp);
    {i_rt_we, i_rt_wdata} = {we, d};
    tick();
    i_rt_we = 0;
    tick();
    chk(o_rt_rdata, exp, "rt_rdata");
  endtask
  task automatic clks(input bit x);
    repeat (3) begin
      if (x) @(i_ext_clk);
      else @(i_ring_osc_clk);
      #1 chk(o_uart_clk, x ? i_ext_clk : i_ring_osc_clk, "uart_clk");
    end
    tick();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    tick(6);
    i_nrst = 1;
    for (int ec = 0; ec < 2; ec++) begin
      rd(ec[0], `UCG_OFS_ACTIVATE, `UCG_RST_ACTIVATE);
      rd(ec[0], `UCG_OFS_CONFIG, `UCG_RST_CONFIG);
      rd(ec[0], 8'h31, 8'h00);
    end
    wr(0, 8'hF0, 8'hFF);
    rd(0, 8'hF0, 8'h01);
    wr(1, 8'hF0, 8'hFF);
    rd(1, 8'hF0, 8'h07);
    wr(1, 8'h30, 8'hFF);
    rd(0, 8'h30, 8'h01);
    wr(0, 8'h30, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(1, 8'h30, e[7:0]);
      for (int s = 0; s < 16; s++) begin
        {i_sleep, act} = s[3:0];
        tick(3);
        chk(o_idle, act == 0, "idle");
        chk(o_clock_required, e == 1 && act != 0, "clock_required");
        chk(o_power_state, e == 0 ? 2'h0 : s[3] ? (act == 0 ? 2'h3 : 2'h2) : 2'h1, "state");
        chk(o_port_enable, e[7:0], "port_enable");
      end
    end
    {i_sleep, act} = 4'h0;
    wr(1, 8'hF0, 8'h00);
    clks(0);
    wr(1, 8'hF0, 8'h01);
    clks(1);
    for (int v = 0; v < 4; v++) begin
      wr(1, 8'hF0, {5'h0, v[1], 2'h0});
      i_core_tx = v[0];
      tick(5);
      chk(o_tx_pin, v[0] ^ v[1], "tx_pin");
      chk(o_core_rx, v[0], "core_rx");
      chk(o_tx_pin_oe_n, 1'b0, "oe_n");
    end
    i_core_tx = 1;
    rt(1, 8'h5A, 8'h5A);
    i_sleep = 1;
    tick(4);
    i_sleep = 0;
    tick(3);
    rt(0, 8'h00, 8'h5A);
    rd(1, 8'hF0, 8'h04);
    wr(1, 8'hF0, 8'h00);
    i_host_side_reset_n = 0;
    tick(4);
    rt(0, 8'h00, 8'h5A);
    chk(o_tx_pin_oe_n, 1'b0, "oe_n");
    i_host_side_reset_n = 1;
    wr(1, 8'hF0, 8'h02);
    i_host_side_reset_n = 0;
    tick(4);
    chk(o_tx_pin_oe_n, 1'b1, "oe_n");
    rt(0, 8'h00, 8'h00);
    i_host_side_reset_n = 1;
    wr(1, 8'hF0, 8'h00);
    tick(3);
    rt(1, 8'hA5, 8'hA5);
    i_nrst = 0;
    tick();
    i_nrst = 1;
    rd(0, 8'h30, 8'h00);
    rt(0, 8'h00, 8'h00);
    stop_test();
  end
endmodule
bind ucg_top ucg_chk u_chk (.*);
`default_nettype wire
